// ==== design/cpw_pkg.sv ====
// shared constants, register map and mode decoding for the compare and pwm unit
`default_nettype none
package cpw_pkg;
    localparam int AW = 4;
    localparam int DW = 8;
    // register word addresses
    localparam logic [3:0] A_U1_CTL = 4'h0;
    localparam logic [3:0] A_U1_LO = 4'h1;
    localparam logic [3:0] A_U1_HI = 4'h2;
    localparam logic [3:0] A_U2_CTL = 4'h3;
    localparam logic [3:0] A_U2_LO = 4'h4;
    localparam logic [3:0] A_U2_HI = 4'h5;
    localparam logic [3:0] A_T2_PER = 4'h6;
    localparam logic [3:0] A_T2_CTL = 4'h7;
    localparam logic [3:0] A_T2_CNT = 4'h8;
    localparam logic [3:0] A_FLAGS = 4'h9;
    localparam logic [3:0] A_PINSEL = 4'ha;
    // mode_select codes
    localparam logic [3:0] M_OFF = 4'h0;
    localparam logic [3:0] M_TOGGLE = 4'h2;
    localparam logic [3:0] M_SET = 4'h8;
    localparam logic [3:0] M_CLR = 4'h9;
    localparam logic [3:0] M_SWIRQ = 4'ha;
    localparam logic [3:0] M_SEV = 4'hb;
    localparam logic [1:0] M_PWM_TOP = 2'h3;
    // field positions
    localparam int CTL_DUTY_LSB = 4;
    localparam int T2_ON_BIT = 2;
    localparam int FLAG_U1 = 0;
    localparam int FLAG_U2 = 1;
    localparam int FLAG_T1OVF = 2;
    localparam int PINSEL_BIT = 0;
    // reset values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] VAL_RST = 8'h00;
    localparam logic [7:0] T2_PER_RST = 8'hff;
    localparam logic [7:0] T2_CTL_RST = 8'h00;
    // timing: one instruction cycle is four system clocks
    localparam logic [1:0] INSTR_LAST_PHASE = 2'h3;
    localparam logic [3:0] PRE_MAX4 = 4'h3;
    localparam logic [3:0] PRE_MAX16 = 4'hf;
    localparam logic [15:0] CLKS_PER_INSTR = 16'h0004;

    function automatic logic is_pwm(input logic [3:0] m);
        return m[3:2] == M_PWM_TOP;
    endfunction

    function automatic logic is_cmp(input logic [3:0] m);
        return (m == M_TOGGLE) || (m[3:2] == 2'h2);
    endfunction

    function automatic logic drives_pin(input logic [3:0] m);
        return is_pwm(m) || m == M_TOGGLE || m == M_SET || m == M_CLR;
    endfunction
endpackage
`default_nettype wire

// ==== design/cpw_tbase_if.sv ====
// timer2 time base carried from the timer to both units
`default_nettype none
interface cpw_tbase_if;
    logic [7:0] count;
    logic [9:0] base;
    logic period_end;
    modport src (output count, output base, output period_end);
    modport snk (input count, input base, input period_end);
endinterface
`default_nettype wire

// ==== design/cpw_timer2_count.sv ====
// timer2 with 1/4/16 prescaler, period match and 10-bit pwm time base
`default_nettype none
module cpw_timer2_count (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [1:0] prescale,
    input wire logic [7:0] period,
    cpw_tbase_if.src tb
);
    logic [1:0] q_ff;
    logic [3:0] pre_ff;
    logic [7:0] cnt_ff;
    logic pe_ff;
    logic [3:0] pre_max;
    logic instr;
    logic step;

    // prescaler terminal count
    always_comb begin
        case (prescale)
            2'h0: pre_max = 4'h0;
            2'h1: pre_max = cpw_pkg::PRE_MAX4;
            default: pre_max = cpw_pkg::PRE_MAX16;
        endcase
    end

    assign instr = enable && (q_ff == cpw_pkg::INSTR_LAST_PHASE);
    assign step = instr && (pre_ff == pre_max);

    // system clock phase, four per instruction cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= 2'h0;
        end else if (enable) begin
            q_ff <= q_ff + 2'h1;
        end
    end

    // prescaler counts instruction cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= 4'h0;
        end else if (step) begin
            pre_ff <= 4'h0;
        end else if (instr) begin
            pre_ff <= pre_ff + 4'h1;
        end
    end

    // count clears on the increment after it equals the period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            pe_ff <= 1'b0;
        end else begin
            pe_ff <= step && (cnt_ff == period);
            if (step) begin
                cnt_ff <= (cnt_ff == period) ? 8'h00 : cnt_ff + 8'h01;
            end
        end
    end

    // low two bits: clock phase at 1:1, else prescaler bits
    always_comb begin
        case (prescale)
            2'h0: tb.base = {cnt_ff, q_ff};
            2'h1: tb.base = {cnt_ff, pre_ff[1:0]};
            default: tb.base = {cnt_ff, pre_ff[3:2]};
        endcase
    end

    assign tb.count = cnt_ff;
    assign tb.period_end = pe_ff;
endmodule
`default_nettype wire

// ==== design/cpw_unit.sv ====
// one compare/pwm unit: control and value registers, compare actions, pwm output
`default_nettype none
module cpw_unit #(
    parameter bit SECOND = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_ctl,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    input wire logic [15:0] t1_count,
    input wire logic adc_en,
    cpw_tbase_if.snk tb,
    output logic [7:0] ctl_ff,
    output logic [7:0] lo_ff,
    output logic [7:0] hi_ff,
    output logic [1:0] dl_ff,
    output logic pin_ff,
    output logic own_ff,
    output logic hit_ff,
    output logic clr_ff,
    output logic adc_ff
);
    logic [3:0] mode;
    logic pwm;
    logic eq;
    logic eq_ff;
    logic hit;

    assign mode = ctl_ff[3:0];
    assign pwm = cpw_pkg::is_pwm(mode);
    assign eq = ({hi_ff, lo_ff} == t1_count);
    assign hit = cpw_pkg::is_cmp(mode) && eq && !eq_ff;

    // control and low value accept writes at any time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= cpw_pkg::CTL_RST;
            lo_ff <= cpw_pkg::VAL_RST;
        end else begin
            if (wr_ctl) begin
                ctl_ff <= {2'h0, wdata[5:0]};
            end
            if (wr_lo) begin
                lo_ff <= wdata;
            end
        end
    end

    // high value: duty buffer in pwm, read-only there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_ff <= cpw_pkg::VAL_RST;
            dl_ff <= 2'h0;
        end else if (pwm && tb.period_end) begin
            hi_ff <= lo_ff;
            dl_ff <= ctl_ff[cpw_pkg::CTL_DUTY_LSB +: 2];
        end else if (wr_hi && !pwm) begin
            hi_ff <= wdata;
        end
    end

    // output latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_ff <= 1'b0;
        end else if (wr_ctl && wdata == 8'h00) begin
            pin_ff <= 1'b0;
        end else if (pwm) begin
            if (tb.period_end) begin
                pin_ff <= ({lo_ff, ctl_ff[5:4]} != 10'h000);
            end else if (tb.base == {hi_ff, dl_ff}) begin
                pin_ff <= 1'b0;
            end
        end else if (hit) begin
            case (mode)
                cpw_pkg::M_TOGGLE: pin_ff <= !pin_ff;
                cpw_pkg::M_SET: pin_ff <= 1'b1;
                cpw_pkg::M_CLR: pin_ff <= 1'b0;
                default: pin_ff <= pin_ff;
            endcase
        end
    end

    // pin ownership, match pulse and special event outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            own_ff <= 1'b0;
            eq_ff <= 1'b0;
            hit_ff <= 1'b0;
            clr_ff <= 1'b0;
            adc_ff <= 1'b0;
        end else begin
            own_ff <= cpw_pkg::drives_pin(mode);
            eq_ff <= eq;
            hit_ff <= hit;
            clr_ff <= (mode == cpw_pkg::M_SEV) && eq;
            adc_ff <= SECOND && hit && mode == cpw_pkg::M_SEV && adc_en;
        end
    end
endmodule
`default_nettype wire

// ==== design/cpw_top.sv ====
// compare and pwm block: register port, timer2, two units, pin routing
//
// Our own choices: the address-and-strobe port and the address map.
`default_nettype none
module cpw_top (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic [15:0] T1_COUNT,
    input wire logic T1_OVERFLOW,
    input wire logic ADC_ENABLED,
    output logic T1_CLEAR,
    output logic ADC_START,
    output logic [2:0] IRQ_FLAGS,
    output logic UNIT1_PIN,
    output logic UNIT1_PIN_OE,
    output logic ALT_PIN_A,
    output logic ALT_PIN_A_OE,
    output logic ALT_PIN_B,
    output logic ALT_PIN_B_OE
);
    logic [7:0] rdata_ff;
    logic [7:0] t2_per_ff;
    logic [7:0] t2_ctl_ff;
    logic [2:0] flags_ff;
    logic pinsel_ff;
    logic t1_clear_ff;
    logic alt_a_ff;
    logic alt_a_oe_ff;
    logic alt_b_ff;
    logic alt_b_oe_ff;
    logic [7:0] rd_mux;
    logic w_u1_ctl;
    logic w_u2_ctl;
    logic w_flags;
    logic [7:0] u1_ctl;
    logic [7:0] u1_lo;
    logic [7:0] u1_hi;
    logic [1:0] u1_dl;
    logic u1_pin;
    logic u1_own;
    logic u1_hit;
    logic u1_clr;
    logic [7:0] u2_ctl;
    logic [7:0] u2_lo;
    logic [7:0] u2_hi;
    logic [1:0] u2_dl;
    logic u2_pin;
    logic u2_own;
    logic u2_hit;
    logic u2_clr;
    logic u2_adc;

    cpw_tbase_if tb ();

    // write strobes for both unit control registers and the flags
    assign w_u1_ctl = REG_WR && REG_ADDR == cpw_pkg::A_U1_CTL;
    assign w_u2_ctl = REG_WR && REG_ADDR == cpw_pkg::A_U2_CTL;
    assign w_flags = REG_WR && REG_ADDR == cpw_pkg::A_FLAGS;

    cpw_timer2_count u_timer2_count (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .enable(t2_ctl_ff[cpw_pkg::T2_ON_BIT]),
        .prescale(t2_ctl_ff[1:0]),
        .period(t2_per_ff),
        .tb(tb.src)
    );

    cpw_unit #(.SECOND(1'b0)) u_unit1 (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .wr_ctl(w_u1_ctl),
        .wr_lo(REG_WR && REG_ADDR == cpw_pkg::A_U1_LO),
        .wr_hi(REG_WR && REG_ADDR == cpw_pkg::A_U1_HI),
        .wdata(REG_WDATA),
        .t1_count(T1_COUNT),
        .adc_en(1'b0),
        .tb(tb.snk),
        .ctl_ff(u1_ctl),
        .lo_ff(u1_lo),
        .hi_ff(u1_hi),
        .dl_ff(u1_dl),
        .pin_ff(u1_pin),
        .own_ff(u1_own),
        .hit_ff(u1_hit),
        .clr_ff(u1_clr),
        .adc_ff()
    );

    cpw_unit #(.SECOND(1'b1)) u_unit2 (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .wr_ctl(w_u2_ctl),
        .wr_lo(REG_WR && REG_ADDR == cpw_pkg::A_U2_LO),
        .wr_hi(REG_WR && REG_ADDR == cpw_pkg::A_U2_HI),
        .wdata(REG_WDATA),
        .t1_count(T1_COUNT),
        .adc_en(ADC_ENABLED),
        .tb(tb.snk),
        .ctl_ff(u2_ctl),
        .lo_ff(u2_lo),
        .hi_ff(u2_hi),
        .dl_ff(u2_dl),
        .pin_ff(u2_pin),
        .own_ff(u2_own),
        .hit_ff(u2_hit),
        .clr_ff(u2_clr),
        .adc_ff(u2_adc)
    );

    // timer2 period, control and second pin select registers
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            t2_per_ff <= cpw_pkg::T2_PER_RST;
            t2_ctl_ff <= cpw_pkg::T2_CTL_RST;
            pinsel_ff <= 1'b0;
        end else if (REG_WR) begin
            case (REG_ADDR)
                cpw_pkg::A_T2_PER: t2_per_ff <= REG_WDATA;
                cpw_pkg::A_T2_CTL: t2_ctl_ff <= {5'h00, REG_WDATA[2:0]};
                cpw_pkg::A_PINSEL: pinsel_ff <= REG_WDATA[cpw_pkg::PINSEL_BIT];
                default: pinsel_ff <= pinsel_ff;
            endcase
        end
    end

    // sticky flags, write one to clear, a new event wins over the clear
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            flags_ff <= 3'h0;
        end else begin
            flags_ff[cpw_pkg::FLAG_U1] <= u1_hit ||
                (flags_ff[cpw_pkg::FLAG_U1] && !(w_flags && REG_WDATA[cpw_pkg::FLAG_U1]));
            flags_ff[cpw_pkg::FLAG_U2] <= u2_hit ||
                (flags_ff[cpw_pkg::FLAG_U2] && !(w_flags && REG_WDATA[cpw_pkg::FLAG_U2]));
            // only a true overflow sets this; the special event clear does not
            flags_ff[cpw_pkg::FLAG_T1OVF] <= T1_OVERFLOW ||
                (flags_ff[cpw_pkg::FLAG_T1OVF] && !(w_flags && REG_WDATA[cpw_pkg::FLAG_T1OVF]));
        end
    end

    // read multiplexer, unmapped addresses read zero
    always_comb begin
        case (REG_ADDR)
            cpw_pkg::A_U1_CTL: rd_mux = u1_ctl;
            cpw_pkg::A_U1_LO: rd_mux = u1_lo;
            cpw_pkg::A_U1_HI: rd_mux = u1_hi;
            cpw_pkg::A_U2_CTL: rd_mux = u2_ctl;
            cpw_pkg::A_U2_LO: rd_mux = u2_lo;
            cpw_pkg::A_U2_HI: rd_mux = u2_hi;
            cpw_pkg::A_T2_PER: rd_mux = t2_per_ff;
            cpw_pkg::A_T2_CTL: rd_mux = t2_ctl_ff;
            cpw_pkg::A_T2_CNT: rd_mux = tb.count;
            cpw_pkg::A_FLAGS: rd_mux = {5'h00, flags_ff};
            cpw_pkg::A_PINSEL: rd_mux = {7'h00, pinsel_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= REG_RD ? rd_mux : 8'h00;
        end
    end

    // timer1 clear request from either unit, dropped at once if the value moved after the trigger
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            t1_clear_ff <= 1'b0;
        end else begin
            t1_clear_ff <= (u1_clr && {u1_hi, u1_lo} == T1_COUNT) ||
                (u2_clr && {u2_hi, u2_lo} == T1_COUNT);
        end
    end

    // second unit pin routed to one of two port pins
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            alt_a_ff <= 1'b0;
            alt_a_oe_ff <= 1'b0;
            alt_b_ff <= 1'b0;
            alt_b_oe_ff <= 1'b0;
        end else begin
            alt_a_ff <= !pinsel_ff && u2_pin;
            alt_a_oe_ff <= !pinsel_ff && u2_own;
            alt_b_ff <= pinsel_ff && u2_pin;
            alt_b_oe_ff <= pinsel_ff && u2_own;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign T1_CLEAR = t1_clear_ff;
    assign ADC_START = u2_adc;
    assign IRQ_FLAGS = flags_ff;
    assign UNIT1_PIN = u1_pin;
    assign UNIT1_PIN_OE = u1_own;
    assign ALT_PIN_A = alt_a_ff;
    assign ALT_PIN_A_OE = alt_a_oe_ff;
    assign ALT_PIN_B = alt_b_ff;
    assign ALT_PIN_B_OE = alt_b_oe_ff;

    // helper: cycles between period ends, valid once settings are steady
    logic [15:0] gap_ff;
    logic gap_ok_ff;
    logic [15:0] ps_val;
    logic [15:0] exp_gap;
    logic u1_pwm;
    logic [3:0] u1_mode;

    assign u1_mode = u1_ctl[3:0];
    assign u1_pwm = cpw_pkg::is_pwm(u1_mode);
    assign ps_val = (t2_ctl_ff[1:0] == 2'h0) ? 16'h0001 : (t2_ctl_ff[1] ? 16'h0010 : 16'h0004);
    assign exp_gap = 16'(({8'h00, t2_per_ff} + 16'h0001) * cpw_pkg::CLKS_PER_INSTR * ps_val);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            gap_ff <= 16'h0000;
            gap_ok_ff <= 1'b0;
        end else begin
            gap_ff <= tb.period_end ? 16'h0001 : gap_ff + 16'h0001;
            if (REG_WR && (REG_ADDR == cpw_pkg::A_T2_PER || REG_ADDR == cpw_pkg::A_T2_CTL)) begin
                gap_ok_ff <= 1'b0;
            end else if (tb.period_end) begin
                gap_ok_ff <= 1'b1;
            end
        end
    end

    pwm_period_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        tb.period_end && gap_ok_ff |-> gap_ff == exp_gap)
        else $error("pwm period length wrong");

    ctl_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        w_u1_ctl && REG_WDATA == 8'h00 |=> !UNIT1_PIN ##1 !UNIT1_PIN_OE)
        else $error("control clear did not drop latch and pin");

    swirq_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        u1_hit && $past(u1_mode) == cpw_pkg::M_SWIRQ |=> IRQ_FLAGS[0] && !UNIT1_PIN_OE)
        else $error("software interrupt match did not set flag");

    sev_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        (u1_mode == cpw_pkg::M_SEV && {u1_hi, u1_lo} == T1_COUNT)[*2] |=> T1_CLEAR && !UNIT1_PIN_OE)
        else $error("special event did not request timer1 clear");

    adc_start_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        ADC_START |-> $past(ADC_ENABLED) && $past(u2_ctl[3:0]) == cpw_pkg::M_SEV)
        else $error("conversion start without enabled special event");

    sev_drop_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        !u1_clr && !u2_clr |=> !T1_CLEAR)
        else $error("timer1 clear held after equality removed");

    ovf_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(IRQ_FLAGS[2]) |-> $past(T1_OVERFLOW))
        else $error("timer1 overflow flag set without overflow");

    pwm_set_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        u1_pwm && tb.period_end && !w_u1_ctl |=> UNIT1_PIN == ($past({u1_lo, u1_ctl[5:4]}) != 10'h000))
        else $error("pwm pin wrong at period end");

    duty_load_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        u1_pwm && tb.period_end |=> u1_hi == $past(u1_lo) && u1_dl == $past(u1_ctl[5:4]))
        else $error("duty not transferred at period end");

    hi_ro_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        u1_pwm && !tb.period_end |=> $stable(u1_hi))
        else $error("high value changed while in pwm");

    pwm_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        u1_pwm && !tb.period_end && !w_u1_ctl && tb.base == {u1_hi, u1_dl} |=> !UNIT1_PIN)
        else $error("pwm pin not cleared at duty match");

    t2_wrap_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        tb.period_end |-> tb.count == 8'h00 && $past(tb.count) == t2_per_ff)
        else $error("timer2 did not clear after period match");

    alt_pin_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        pinsel_ff && u2_own |=> ALT_PIN_B_OE && !ALT_PIN_A_OE)
        else $error("second unit pin routed to wrong port pin");
endmodule
`default_nettype wire

// ==== testbench/cpw_load_model.sv ====
// load on a unit pin: pull-down wire with pulse and period meter
`default_nettype none
module cpw_load_model (
    input wire logic clk,
    input wire logic pin,
    input wire logic oe,
    output logic level,
    output logic [15:0] hi_len,
    output logic [15:0] per_len,
    output logic [15:0] hi_total
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run_hi;
    logic [15:0] run_per;
    logic prev;
    initial begin
        {run_hi, run_per, prev, hi_len, per_len, hi_total} = '0;
    end
    // an undriven pin falls to the pull-down, so it only counts while output
    assign level = oe ? pin : 1'b0;
    // high pulse length, rise-to-rise distance and total high time
    always @(posedge clk) begin
        prev <= level;
        run_per <= (level && !prev) ? 16'h0001 : run_per + 16'h0001;
        run_hi <= level ? run_hi + 16'h0001 : 16'h0000;
        if (level && !prev) per_len <= run_per;
        if (!level && prev) hi_len <= run_hi;
        if (level) hi_total <= hi_total + 16'h0001;
    end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench: registers, compare actions, pwm on the alternate pin
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] t1 = 16'h0000;
    logic t1_ovf = 1'b0;
    logic adc_en = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] rdata, nt;
    logic t1_clr, adc_go, u1_pin, u1_oe, pa, pa_oe, pb, pb_oe, lvl;
    logic [2:0] flags;
    logic [15:0] hi_len, per_len, hi_total, snap, v;
    logic [9:0] d;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 32'h4624;
    int mul;
    always #2.5 clk = ~clk;
    cpw_top u_cpw_top (.CLK_SYS(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .T1_COUNT(t1), .T1_OVERFLOW(t1_ovf), .ADC_ENABLED(adc_en),
        .T1_CLEAR(t1_clr), .ADC_START(adc_go), .IRQ_FLAGS(flags), .UNIT1_PIN(u1_pin), .UNIT1_PIN_OE(u1_oe),
        .ALT_PIN_A(pa), .ALT_PIN_A_OE(pa_oe), .ALT_PIN_B(pb), .ALT_PIN_B_OE(pb_oe));
    cpw_load_model u_cpw_load_model (.clk(clk), .pin(pb), .oe(pb_oe), .level(lvl), .hi_len(hi_len),
        .per_len(per_len), .hi_total(hi_total));
    task automatic wreg(input logic [3:0] a, input logic [7:0] dv);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dv;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // timer1 count steps only on system clock edges, never asynchronously
    task automatic hit(input logic [15:0] m);
        @(posedge clk);
        t1 <= m;
        @(posedge clk);
        t1 <= ~m;
        #1;
    endtask
    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // read data stand one cycle after the strobe; take the oldest note
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            nt = exp_q.pop_front();
            `CHK("rdata", nt, rdata)
        end
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rreg(cpw_pkg::A_U1_CTL, 8'h00);
        rreg(cpw_pkg::A_T2_PER, 8'hff);
        rreg(cpw_pkg::A_T2_CTL, 8'h00);
        rreg(4'hf, 8'h00);
        $display("test regs done");
        v = $random(seed) | 16'h0001;
        wreg(cpw_pkg::A_U1_HI, v[15:8]);
        wreg(cpw_pkg::A_U1_LO, v[7:0]);
        wreg(cpw_pkg::A_U1_CTL, cpw_pkg::M_SET);
        hit(v);
        `CHK("set", 2'b11, {u1_pin, u1_oe})
        wreg(cpw_pkg::A_U1_CTL, cpw_pkg::M_CLR);
        hit(v);
        `CHK("clr", 2'b01, {u1_pin, u1_oe})
        wreg(cpw_pkg::A_U1_CTL, cpw_pkg::M_TOGGLE);
        hit(v);
        `CHK("tgl", 3'b111, {u1_pin, u1_oe, flags[0]})
        wreg(cpw_pkg::A_U1_CTL, 8'h00);
        @(posedge clk);
        #1;
        `CHK("off", 2'b00, {u1_pin, u1_oe})
        wreg(cpw_pkg::A_FLAGS, 8'h01);
        wreg(cpw_pkg::A_U1_CTL, cpw_pkg::M_SWIRQ);
        hit(v);
        @(posedge clk);
        #1;
        `CHK("swirq", 2'b10, {flags[0], u1_oe})
        $display("test compare done");
        wreg(cpw_pkg::A_U1_CTL, 8'h00);
        wreg(cpw_pkg::A_FLAGS, 8'h07);
        adc_en <= 1'b1;
        wreg(cpw_pkg::A_U2_HI, v[15:8]);
        wreg(cpw_pkg::A_U2_LO, v[7:0]);
        wreg(cpw_pkg::A_U2_CTL, cpw_pkg::M_SEV);
        @(posedge clk);
        t1 <= v;
        @(posedge clk);
        #1;
        `CHK("trig", 2'b10, {adc_go, t1_clr})
        @(posedge clk);
        #1;
        `CHK("t1 clear", 4'b0100, {adc_go, t1_clr, pa_oe, pb_oe})
        @(posedge clk);
        t1 <= 16'h0000;
        rreg(cpw_pkg::A_FLAGS, 8'h02);
        // move the value away between trigger and timer1 reset
        @(posedge clk);
        t1 <= v;
        wr <= 1'b1;
        addr <= cpw_pkg::A_U2_LO;
        wdata <= v[7:0] ^ 8'h80;
        @(posedge clk);
        wr <= 1'b0;
        #1;
        `CHK("trig2", 1'b1, adc_go)
        @(posedge clk);
        #1;
        `CHK("no clear", 1'b0, t1_clr)
        @(posedge clk);
        t1_ovf <= 1'b1;
        @(posedge clk);
        t1_ovf <= 1'b0;
        rreg(cpw_pkg::A_FLAGS, 8'h06);
        wreg(cpw_pkg::A_U2_CTL, 8'h00);
        $display("test event done");
        wreg(cpw_pkg::A_PINSEL, 8'h01);
        wreg(cpw_pkg::A_T2_PER, 8'h03);
        for (int i = 0; i < 3; i++) begin
            d = 10'd1 + 10'($unsigned($random(seed)) % 15);
            mul = 1 << (2 * i);
            wreg(cpw_pkg::A_U2_CTL, {2'b00, d[1:0], 4'hc});
            wreg(cpw_pkg::A_U2_LO, d[9:2]);
            wreg(cpw_pkg::A_U1_CTL, {2'b00, d[1:0], 4'hc});
            wreg(cpw_pkg::A_U1_LO, d[9:2]);
            wreg(cpw_pkg::A_T2_CTL, {5'h00, 1'b1, 2'(i)});
            repeat (48 * mul) @(posedge clk);
            #1;
            `CHK("high", 16'(d * mul), hi_len)
            `CHK("period", 16'(16 * mul), per_len)
            `CHK("pins", 2'b01, {pa_oe, pb_oe})
            wreg(cpw_pkg::A_U2_HI, 8'ha5);
            rreg(cpw_pkg::A_U2_HI, d[9:2]);
        end
        wreg(cpw_pkg::A_U2_LO, 8'h00);
        wreg(cpw_pkg::A_U2_CTL, 8'h0c);
        repeat (512) @(posedge clk);
        snap = hi_total;
        repeat (256) @(posedge clk);
        #1;
        `CHK("zero duty", snap, hi_total)
        wreg(cpw_pkg::A_U2_CTL, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        `CHK("release", 1'b0, pb_oe)
        $display("test pwm done");
        end_sim();
    end
endmodule
`default_nettype wire
